// ---- iox_dev.sv ----
/*
 * Expander end: a two-wire slave clocked by the bus clock that
 * latches written pairs onto the quasi-bidirectional port and
 * returns the port levels on reads, plus the change alert logic
 * on the system clock. Assumes the master ends reads with a
 * not-acknowledge and that addressing is decoded elsewhere.
 */
`timescale 1ns/1ps
module iox_dev (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    iox_link_if.dev link,
    input wire logic [iox_pkg::PORT_W-1:0] port_i,
    output logic [iox_pkg::PORT_W-1:0] port_o,
    output logic [iox_pkg::PORT_W-1:0] port_oe_o,
    output logic alert_o
);
    import iox_pkg::*;

    // Bus clock domain state
    typedef struct packed {
        iox_phase_e phase;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic hi;
        logic [15:0] latch;
        logic [7:0] rd;
        logic start_seen;
        logic wr_tog;
        logic rd_tog;
        logic [15:0] pin_m;
        logic [15:0] pin_s;
    } iox_lnk_s;

    // System clock domain state
    typedef struct packed {
        logic wr_m;
        logic wr_s;
        logic wr_d;
        logic rd_m;
        logic rd_s;
        logic rd_d;
        logic [15:0] pin_m;
        logic [15:0] pin_s;
        logic [15:0] snap;
        logic alert;
    } iox_sys_s;

    iox_lnk_s l_r;
    iox_lnk_s l_nxt;
    iox_sys_s s_r;
    iox_sys_s s_nxt;
    logic rst_n;
    logic start_tog_r;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic access_ev;

    // Power-on reset and the reset pin both hold every register
    assign rst_n = arst_n_i & link.rst_n;

    // Start condition: SDA falling while SCL is high flips a toggle
    always_ff @(negedge link.sda or negedge rst_n)
    begin
        if (!rst_n)
            start_tog_r <= 1'b0;
        else if (link.scl)
            start_tog_r <= !start_tog_r;
    end

    // Receive, transmit and latch sequencing on rising SCL
    always_comb
    begin
        l_nxt = l_r;
        l_nxt.pin_m = port_i;
        l_nxt.pin_s = l_r.pin_m;
        if (start_tog_r != l_r.start_seen)
        begin
            // First address bit arrives on the first rising edge
            l_nxt.start_seen = start_tog_r;
            l_nxt.phase = PH_ADDR;
            l_nxt.cnt = 4'h1;
            l_nxt.sh = {7'h00, link.sda};
        end
        else
        begin
            case (l_r.phase)
                PH_ADDR, PH_WR:
                begin
                    if (l_r.cnt < BYTE_BITS)
                    begin
                        l_nxt.sh = {l_r.sh[6:0], link.sda};
                        l_nxt.cnt = l_r.cnt + 4'h1;
                    end
                    else if (l_r.phase == PH_ADDR)
                    begin
                        // Acknowledge slot of the address byte
                        l_nxt.cnt = 4'h0;
                        l_nxt.hi = 1'b0;
                        if (l_r.sh[0])
                        begin
                            l_nxt.phase = PH_RD;
                            l_nxt.rd = l_r.pin_s[7:0];
                            l_nxt.rd_tog = !l_r.rd_tog;
                        end
                        else
                            l_nxt.phase = PH_WR;
                    end
                    else
                    begin
                        // Acknowledged data byte goes to its port half
                        l_nxt.cnt = 4'h0;
                        if (l_r.hi)
                            l_nxt.latch[15:8] = l_r.sh;
                        else
                            l_nxt.latch[7:0] = l_r.sh;
                        l_nxt.hi = !l_r.hi;
                        l_nxt.wr_tog = !l_r.wr_tog;
                    end
                end
                PH_RD:
                begin
                    if (l_r.cnt < BYTE_BITS)
                    begin
                        l_nxt.rd = {l_r.rd[6:0], 1'b0};
                        l_nxt.cnt = l_r.cnt + 4'h1;
                    end
                    else
                    begin
                        // Master acknowledge asks for the next byte
                        l_nxt.cnt = 4'h0;
                        if (!link.sda)
                        begin
                            l_nxt.hi = !l_r.hi;
                            l_nxt.rd = l_r.hi ? l_r.pin_s[7:0]
                                              : l_r.pin_s[15:8];
                            l_nxt.rd_tog = !l_r.rd_tog;
                        end
                        else
                            l_nxt.phase = PH_IDLE;
                    end
                end
                default: l_nxt.phase = PH_IDLE;
            endcase
        end
    end

    // Bus clock domain register
    always_ff @(posedge link.scl or negedge rst_n)
    begin
        if (!rst_n)
            l_r <= '{phase: PH_IDLE, latch: LATCH_RST, pin_m: LATCH_RST,
                     pin_s: LATCH_RST, default: '0};
        else
            l_r <= l_nxt;
    end

    // SDA drive: acknowledge and read data, changed while SCL is low
    always_comb
    begin
        sda_oe_nxt = 1'b0;
        if ((l_r.phase == PH_ADDR || l_r.phase == PH_WR)
            && l_r.cnt == BYTE_BITS)
            sda_oe_nxt = 1'b1;
        else if (l_r.phase == PH_RD && l_r.cnt < BYTE_BITS)
            sda_oe_nxt = !l_r.rd[7];
    end

    // Data line enable register on falling SCL
    always_ff @(negedge link.scl or negedge rst_n)
    begin
        if (!rst_n)
            sda_oe_r <= 1'b0;
        else
            sda_oe_r <= sda_oe_nxt;
    end

    // Access toggles cross to the system clock, pins are synchronised
    assign access_ev = (s_r.wr_s ^ s_r.wr_d) | (s_r.rd_s ^ s_r.rd_d);

    // Change alert: compare the pins with the snapshot of last access
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.wr_m = l_r.wr_tog;
        s_nxt.wr_s = s_r.wr_m;
        s_nxt.wr_d = s_r.wr_s;
        s_nxt.rd_m = l_r.rd_tog;
        s_nxt.rd_s = s_r.rd_m;
        s_nxt.rd_d = s_r.rd_s;
        s_nxt.pin_m = port_i;
        s_nxt.pin_s = s_r.pin_m;
        if (access_ev)
        begin
            // An access takes a new snapshot and drops the alert
            s_nxt.snap = s_r.pin_s;
            s_nxt.alert = 1'b0;
        end
        else
            s_nxt.alert = (s_r.pin_s != s_r.snap);
    end

    // System clock domain register
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '{pin_m: LATCH_RST, pin_s: LATCH_RST, snap: LATCH_RST,
                     default: '0};
        else
            s_r <= s_nxt;
    end

    // Open-drain outputs: drive low only, release otherwise
    assign link.sda_d_o = 1'b0;
    assign link.sda_d_oe = sda_oe_r;
    assign link.alert_o = 1'b0;
    assign link.alert_oe = s_r.alert;
    assign port_o = '0;
    assign port_oe_o = ~l_r.latch; // Latch low sinks, high is weak pull-up
    assign alert_o = s_r.alert;
endmodule

// ---- iox_pkg.sv ----
/*
 * Shared constants and types of the 16-bit port expander link:
 * the expander end with its change alert, and the bus master end.
 * Assumes a 25 MHz system clock at the master and that the bench
 * resolves the open-drain wires through the link interface.
 */
// Functional notes
// - Alert is open-drain, pulled low when active
// - Any rising or falling input edge raises alert
// - Alert drops on level return or access
// - Write strobe releases alert by its end
// - Read sample strobe clears the alert
// - Changes during clearing may be missed
// - After clearing, every change alerts again
// - Master holds reset pin low minimum width
// - Reset pin low holds latches and sequencer
// - Master starts only on an idle bus
// - Master writes one to input pins
// - Read returns pin levels, outputs read latch
// - Tied pins in one octal get equal values
// - Write pairs go low byte then high
// - Byte drives pins only after acknowledge
// - Read pairs low then high while acked
// - Any reset sets all port latches high
package iox_pkg;
    localparam int PORT_W = 16;
    localparam logic [15:0] LATCH_RST = 16'hFFFF;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int SYS_CLK_NS = 40;
    // Quarter of a 1 MHz bus clock period, rounded up to whole cycles
    localparam int QUARTER_NS = 250;
    localparam int QUARTER_CYC = (QUARTER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [3:0] Q_LAST = 4'(QUARTER_CYC - 1);
    // Reset pin low time, rounded up to whole cycles
    localparam int MIN_RESET_PULSE_WIDTH_NS = 500;
    localparam int RST_CYC =
        (MIN_RESET_PULSE_WIDTH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [7:0] RST_LAST = 8'(RST_CYC - 1);
    localparam logic [6:0] DEV_ADDR = 7'h20;
    // Address byte, two data bytes, each followed by an acknowledge slot
    localparam logic [5:0] LAST_BIT = 6'h1A;
    localparam logic [5:0] SLOT_BITS = 6'h09;
    typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_WR, PH_RD} iox_phase_e;
    typedef enum logic [2:0] {
        HS_IDLE, HS_RST, HS_START, HS_BIT, HS_STOP
    } iox_hstate_e;
endpackage

// ---- iox_link_if.sv ----
/*
 * Two-wire link between the master and the expander, plus the
 * alert and reset pins. Resolves the open-drain levels from the
 * drivers' enables; clock, data and alert wires are pulled high when undriven.
 */
`timescale 1ns/1ps
interface iox_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_h_o;
    logic sda_h_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic alert_o;
    logic alert_oe;
    logic rst_n;
    logic scl;
    logic sda;
    logic alert_n;

    // Wired-AND resolution with pull-ups
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = (sda_h_oe ? sda_h_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);
    assign alert_n = alert_oe ? alert_o : 1'b1;

    modport host (
        output scl_o, scl_oe, sda_h_o, sda_h_oe, rst_n,
        input scl, sda, alert_n
    );
    modport dev (
        output sda_d_o, sda_d_oe, alert_o, alert_oe,
        input scl, sda, rst_n
    );
endinterface

// ---- iox_host.sv ----
/*
 * Bus master end: sends one write pair or reads one pair per
 * request, pulses the reset pin on demand and reports the alert.
 * Assumes the expander answers on every address byte.
 */
`timescale 1ns/1ps
module iox_host (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    iox_link_if.host link,
    input wire logic start_i,
    input wire logic rw_i,
    input wire logic [iox_pkg::PORT_W-1:0] wdata_i,
    input wire logic reset_req_i,
    output logic busy_o,
    output logic done_o,
    output logic [iox_pkg::PORT_W-1:0] rdata_o,
    output logic alert_o
);
    import iox_pkg::*;

    typedef struct packed {
        iox_hstate_e st;
        logic [3:0] div;
        logic [1:0] q;
        logic [5:0] bit_no;
        logic [26:0] tx;
        logic [15:0] rx;
        logic [15:0] rdata;
        logic rw;
        logic scl_lvl;
        logic sda_lvl;
        logic rst_lvl;
        logic [7:0] rst_cnt;
        logic done;
        logic sda_m;
        logic sda_s;
        logic al_m;
        logic al_s;
    } iox_host_s;

    iox_host_s h_r;
    iox_host_s h_nxt;

    // Level the master puts on SDA for a given bit of the frame
    function automatic logic bit_level(logic [5:0] b, logic rw,
                                       logic [26:0] tx);
        logic [5:0] pos;
        logic [5:0] byt;
        pos = b % SLOT_BITS;
        byt = b / SLOT_BITS;
        if (pos == 6'h08)
            bit_level = !(rw && byt == 6'h01); // Ack the low read byte only
        else if (rw && byt != 6'h00)
            bit_level = 1'b1;
        else
            bit_level = tx[5'(6'h1A - (byt * 6'h08 + pos))];
    endfunction

    // Next-state logic of the sequencer and bus clock divider
    always_comb
    begin
        logic tick;
        logic [5:0] pos;
        tick = 1'b0;
        pos = 6'h00;
        h_nxt = h_r;
        h_nxt.done = 1'b0;
        h_nxt.sda_m = link.sda;
        h_nxt.sda_s = h_r.sda_m;
        h_nxt.al_m = link.alert_n;
        h_nxt.al_s = h_r.al_m;
        tick = (h_r.div == Q_LAST);
        h_nxt.div = tick ? 4'h0 : h_r.div + 4'h1;
        if (tick && h_r.st != HS_IDLE)
            h_nxt.q = h_r.q + 2'h1;
        case (h_r.st)
            HS_IDLE:
            begin
                h_nxt.q = 2'h0;
                if (reset_req_i)
                begin
                    h_nxt.st = HS_RST;
                    h_nxt.rst_lvl = 1'b0;
                    h_nxt.rst_cnt = RST_LAST;
                end
                else if (start_i && h_r.scl_lvl && h_r.sda_s)
                begin
                    h_nxt.st = HS_START;
                    h_nxt.rw = rw_i;
                    // Three spare low bits keep the frame left aligned
                    h_nxt.tx = {DEV_ADDR, rw_i, wdata_i[7:0],
                                wdata_i[15:8], 3'h0};
                end
            end
            HS_RST:
            begin
                if (h_r.rst_cnt == 8'h00)
                begin
                    h_nxt.rst_lvl = 1'b1;
                    h_nxt.st = HS_IDLE;
                end
                else
                    h_nxt.rst_cnt = h_r.rst_cnt - 8'h01;
            end
            HS_START:
                if (tick)
                begin
                    if (h_r.q == 2'h1)
                        h_nxt.sda_lvl = 1'b0;
                    if (h_r.q == 2'h3)
                    begin
                        h_nxt.scl_lvl = 1'b0;
                        h_nxt.bit_no = 6'h00;
                        h_nxt.st = HS_BIT;
                    end
                end
            HS_BIT:
                if (tick)
                begin
                    pos = h_r.bit_no % SLOT_BITS;
                    case (h_r.q)
                        2'h0: h_nxt.sda_lvl = bit_level(h_r.bit_no, h_r.rw,
                                                        h_r.tx);
                        2'h1: h_nxt.scl_lvl = 1'b1;
                        2'h2:
                            if (h_r.rw && h_r.bit_no > 6'h08 && pos != 6'h08)
                                h_nxt.rx = {h_r.rx[14:0], h_r.sda_s};
                        default:
                        begin
                            h_nxt.scl_lvl = 1'b0;
                            if (h_r.bit_no == LAST_BIT)
                                h_nxt.st = HS_STOP;
                            else
                                h_nxt.bit_no = h_r.bit_no + 6'h01;
                        end
                    endcase
                end
            HS_STOP:
                if (tick)
                begin
                    case (h_r.q)
                        2'h0: h_nxt.sda_lvl = 1'b0;
                        2'h1: h_nxt.scl_lvl = 1'b1;
                        2'h2: h_nxt.sda_lvl = 1'b1;
                        default:
                        begin
                            h_nxt.st = HS_IDLE;
                            h_nxt.done = 1'b1;
                            h_nxt.rdata = {h_r.rx[7:0], h_r.rx[15:8]};
                        end
                    endcase
                end
            default: h_nxt.st = HS_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            h_r <= '{st: HS_IDLE, scl_lvl: 1'b1, sda_lvl: 1'b1,
                     rst_lvl: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
                     al_m: 1'b1, al_s: 1'b1, default: '0};
        else
            h_r <= h_nxt;
    end

    assign link.scl_o = 1'b0;
    assign link.scl_oe = !h_r.scl_lvl;
    assign link.sda_h_o = 1'b0;
    assign link.sda_h_oe = !h_r.sda_lvl;
    assign link.rst_n = h_r.rst_lvl;
    assign busy_o = (h_r.st != HS_IDLE);
    assign done_o = h_r.done;
    assign rdata_o = h_r.rdata;
    assign alert_o = !h_r.al_s;
endmodule

// ---- iox_link_asserts.sv ----
/*
 * Concurrent checks on the expander link wires and reset pin.
 * Assumes the bench places it beside the link interface.
 */
`timescale 1ns/1ps
module iox_link_asserts (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_d_oe_i,
    input wire logic alert_drv_i,
    input wire logic alert_oe_i,
    input wire logic alert_n_i,
    input wire logic rst_n_i
);
    import iox_pkg::*;
    logic [7:0] low_cnt_r;
    logic [10:0] hi_cnt_r;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    // Reset pin low time and alert high time, both saturating
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            low_cnt_r <= 8'h00;
            hi_cnt_r <= 11'h000;
        end
        else
        begin
            if (rst_n_i)
                low_cnt_r <= 8'h00;
            else if (low_cnt_r != 8'hFF)
                low_cnt_r <= low_cnt_r + 8'h01;
            if (!alert_oe_i)
                hi_cnt_r <= 11'h000;
            else if (hi_cnt_r != 11'h7FF)
                hi_cnt_r <= hi_cnt_r + 11'h001;
        end
    end

    // Bus conditions made by the master
    sequence start_s;
        scl_i && $fell(sda_i);
    endsequence
    sequence stop_s;
        scl_i && $rose(sda_i);
    endsequence

    AST_ALERT_OPEN_DRAIN: assert property (
        alert_oe_i |-> !alert_drv_i && !alert_n_i)
        else $error("alert driven but wire not low");
    AST_RST_PIN_WIDTH: assert property (
        $rose(rst_n_i) |-> low_cnt_r >= RST_CYC)
        else $error("reset pin pulse too short");
    AST_RST_HOLDS_ALERT: assert property (
        !rst_n_i |-> !alert_oe_i)
        else $error("alert active while reset pin low");
    AST_RST_HOLDS_SDA: assert property (
        !rst_n_i |-> !sda_d_oe_i)
        else $error("data line driven while reset pin low");
    AST_IDLE_BEFORE_START: assert property (
        start_s |-> $past(scl_i, 2) && $past(sda_i, 2))
        else $error("start on a busy bus");
    AST_IDLE_AFTER_STOP: assert property (
        stop_s |=> (scl_i && sda_i) [*2])
        else $error("bus not idle after stop");
    AST_SDA_MOVES_SCL_LOW: assert property (
        @(posedge sys_clk_i) disable iff (!arst_n_i || !rst_n_i)
        $changed(sda_d_oe_i) |-> !scl_i)
        else $error("device data moved while clock high");
    AST_ALERT_GONE_BY_STOP: assert property (
        stop_s |-> hi_cnt_r < 11'h190)
        else $error("alert not withdrawn by the access");
endmodule

// ---- io_expander_change_interrupt_tb.sv ----
/*
 * Self-checking bench: master and expander joined by the link.
 * Assumes the master makes the bus clock; pins modelled here.
 */
`timescale 1ns/1ps
module io_expander_change_interrupt_tb;
    import iox_pkg::*;
    localparam int LIMIT = 20000;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b1;
    logic start_i = 1'b0;
    logic rw_i = 1'b0;
    logic [15:0] wdata_i = 16'h0000;
    logic reset_req_i = 1'b0;
    logic [15:0] ext_pins = 16'hFFFF;
    logic [15:0] port_i;
    logic [15:0] port_o;
    logic [15:0] port_oe_o;
    logic [15:0] rdata_o;
    logic busy_o;
    logic done_o;
    logic host_alert;
    logic dev_alert;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;

    iox_link_if link ();

    // Quasi pins: a latch pulling low wins over the outside
    assign port_i = ext_pins & ~port_oe_o;

    iox_host u_iox_host (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .link(link),
        .start_i(start_i),
        .rw_i(rw_i),
        .wdata_i(wdata_i),
        .reset_req_i(reset_req_i),
        .busy_o(busy_o),
        .done_o(done_o),
        .rdata_o(rdata_o),
        .alert_o(host_alert)
    );

    iox_dev u_iox_dev (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .link(link),
        .port_i(port_i),
        .port_o(port_o),
        .port_oe_o(port_oe_o),
        .alert_o(dev_alert)
    );

    iox_link_asserts u_iox_link_asserts (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .scl_i(link.scl),
        .sda_i(link.sda),
        .sda_d_oe_i(link.sda_d_oe),
        .alert_drv_i(link.alert_o),
        .alert_oe_i(link.alert_oe),
        .alert_n_i(link.alert_n),
        .rst_n_i(link.rst_n)
    );

    // System clock, 40 ns
    always #20 sys_clk_i = ~sys_clk_i;

    // Cuts a hang short
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    // One frame through the master, waits for its completion
    task automatic xfer(input logic rd, input logic [15:0] wd);
        int i;
        @(negedge sys_clk_i);
        start_i = 1'b1;
        rw_i = rd;
        wdata_i = wd;
        @(negedge sys_clk_i);
        start_i = 1'b0;
        check("busy", 16'(busy_o), 16'h0001);
        for (i = 0; i < 3000 && done_o !== 1'b1; i++)
            @(negedge sys_clk_i);
        check("done", 16'(done_o), 16'h0001);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence of tests
    initial
    begin
        // Drop reset once every process waits on its edges
        #1 arst_n_i = 1'b0;
        wait_cyc(4);
        arst_n_i = 1'b1;
        wait_cyc(3);
        check("latch", port_oe_o, 16'h0000);
        check("alert wire", 16'(link.alert_n), 16'h0001);
        $display("test reset done");
        // Pending alert, then a write pair withdraws it
        ext_pins = 16'hFFFE;
        wait_cyc(12);
        check("alert", 16'(dev_alert), 16'h0001);
        xfer(1'b0, 16'hA55A);
        ext_pins = 16'hFFFF;
        check("latch", port_oe_o, ~16'hA55A);
        wait_cyc(12);
        check("alert", 16'(dev_alert), 16'h0000);
        xfer(1'b0, 16'hFFFF);
        check("latch", port_oe_o, 16'h0000);
        $display("test write done");
        // Falling edge, then return to the old level
        ext_pins = 16'hFEFF;
        wait_cyc(12);
        check("alert", 16'(host_alert), 16'h0001);
        check("alert wire", 16'(link.alert_n), 16'h0000);
        ext_pins = 16'hFFFF;
        wait_cyc(12);
        check("alert", 16'(host_alert), 16'h0000);
        // A read returns the pins and clears the alert
        ext_pins = 16'h7FFE;
        wait_cyc(12);
        check("alert", 16'(dev_alert), 16'h0001);
        xfer(1'b1, 16'h0000);
        check("read", rdata_o, 16'h7FFE);
        wait_cyc(12);
        check("alert", 16'(dev_alert), 16'h0000);
        // Rising edge after the clear, then a write clears
        ext_pins = 16'hFFFF;
        wait_cyc(12);
        check("alert", 16'(host_alert), 16'h0001);
        xfer(1'b0, 16'h00FF);
        check("latch", port_oe_o, 16'hFF00);
        wait_cyc(12);
        check("alert", 16'(dev_alert), 16'h0000);
        xfer(1'b1, 16'h0000);
        check("read", rdata_o, 16'h00FF);
        $display("test alert done");
        // Reset pin pulse from the master clears a pending alert
        ext_pins = 16'hFFFE;
        wait_cyc(12);
        check("alert", 16'(dev_alert), 16'h0001);
        @(negedge sys_clk_i);
        reset_req_i = 1'b1;
        @(negedge sys_clk_i);
        reset_req_i = 1'b0;
        wait_cyc(2);
        check("reset pin", 16'(link.rst_n), 16'h0000);
        check("latch", port_oe_o, 16'h0000);
        check("alert", 16'(dev_alert), 16'h0000);
        wait_cyc(20);
        check("latch", port_oe_o, 16'h0000);
        xfer(1'b0, 16'h1234);
        check("latch", port_oe_o, ~16'h1234);
        $display("test reset pin done");
        end_sim();
    end
endmodule
